// [rxc_consts.vh]
// Constants for the reference and excitation configuration block
`ifndef RXC_CONSTS_VH
`define RXC_CONSTS_VH

// ********************
// Register map
// ********************
`define RXC_ADDR_W          8
`define RXC_IDX_REFCTL      8'h05
`define RXC_IDX_MAG         8'h06
`define RXC_RST_REFCTL      8'h10
`define RXC_RST_MAG         8'h00
`define RXC_REFCTL_WMASK    8'h7f
`define RXC_MAG_WMASK       8'h0f

// ********************
// Field positions
// ********************
`define RXC_BIT_MON         6
`define RXC_BIT_PBYP        5
`define RXC_BIT_NBYP        4
`define RXC_SEL_HI          3
`define RXC_SEL_LO          2
`define RXC_PWR_HI          1
`define RXC_PWR_LO          0
`define RXC_MAG_HI          3
`define RXC_MAG_LO          0

// ********************
// Encodings
// ********************
`define RXC_SEL_PAIR0       2'h0
`define RXC_SEL_PAIR1       2'h1
`define RXC_SEL_INTERNAL    2'h2
`define RXC_PWR_OFF         2'h0
`define RXC_PWR_SLEEPOFF    2'h1
`define RXC_PWR_ALWAYS      2'h2
`define RXC_RESP_OKAY       2'h0
`define RXC_RESP_SLVERR     2'h2

`endif

// [rxc_mag_decode.v]
// Magnitude code to excitation current in microamps
`timescale 1ns/100ps
`include "rxc_consts.vh"

module rxc_mag_decode (
  // Clock
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        ce,
  // Code in
  input  wire [3:0]  code,
  // Current out
  output reg  [11:0] microamps_q,
  output reg         code_valid_q
);

  // ********************
  // Current table
  // ********************
  function [12:0] lookup;
    input [3:0] c;
    begin
      case (c)
        4'h0:    lookup = {1'b1, 12'h000};
        4'h1:    lookup = {1'b1, 12'h00a};
        4'h2:    lookup = {1'b1, 12'h032};
        4'h3:    lookup = {1'b1, 12'h064};
        4'h4:    lookup = {1'b1, 12'h0fa};
        4'h5:    lookup = {1'b1, 12'h1f4};
        4'h6:    lookup = {1'b1, 12'h2ee};
        4'h7:    lookup = {1'b1, 12'h3e8};
        4'h8:    lookup = {1'b1, 12'h5dc};
        4'h9:    lookup = {1'b1, 12'h7d0};
        default: lookup = {1'b0, 12'h000};
      endcase
    end
  endfunction

  always @(posedge aclk) begin
    if (!aresetn) begin
      microamps_q  <= 12'h000;
      code_valid_q <= 1'b1;
    end else if (ce) begin
      {code_valid_q, microamps_q} <= lookup(code);
    end
  end

endmodule // rxc_mag_decode

// [rxc_field_decode.v]
// One-hot decode of two-bit selection fields
`timescale 1ns/100ps
`include "rxc_consts.vh"

module rxc_field_decode (
  // Clock
  input  wire       aclk,
  input  wire       aresetn,
  input  wire       ce,
  // Fields in
  input  wire [1:0] sel,
  input  wire [1:0] pwr,
  // Decoded out
  output reg  [3:0] sel_onehot_q,
  output reg  [3:0] pwr_onehot_q
);

  function [3:0] onehot;
    input [1:0] v;
    begin
      onehot = 4'h1 << v;
    end
  endfunction

  always @(posedge aclk) begin
    if (!aresetn) begin
      sel_onehot_q <= 4'h1;
      pwr_onehot_q <= 4'h1;
    end else if (ce) begin
      sel_onehot_q <= onehot(sel);
      pwr_onehot_q <= onehot(pwr);
    end
  end

endmodule // rxc_field_decode

// [rxc_ref_exc_regs.v]
// Reference control and excitation magnitude registers behind AXI4-Lite
`timescale 1ns/100ps
`include "rxc_consts.vh"

module rxc_ref_exc_regs #(
  parameter ADDR_W = `RXC_ADDR_W
) (
  // Clock and reset
  input  wire              aclk,
  input  wire              aresetn,
  input  wire              ce,
  // Write address
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire [2:0]        s_axi_awprot,
  // Write data
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  // Write response
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  output reg  [1:0]        s_axi_bresp,
  // Read address
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire [2:0]        s_axi_arprot,
  // Read data
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  // Reference controls
  output reg               ext_monitor_enable,
  output reg               pos_buffer_bypass,
  output reg               neg_buffer_bypass,
  output reg  [1:0]        basis_input_select,
  output reg  [1:0]        internal_basis_power,
  output wire [3:0]        basis_select_onehot,
  output wire [3:0]        basis_power_onehot,
  output reg               internal_basis_on,
  // Excitation controls
  output reg  [3:0]        current_magnitude_code,
  output wire [11:0]       current_source_one,
  output wire [11:0]       current_source_two,
  output wire              current_code_valid,
  // Status
  output reg               basis_warning
);

  // ********************
  // Registers
  // ********************
  reg  [7:0]        ref_q;
  reg  [7:0]        mag_q;
  reg               aw_hold_q;
  reg  [ADDR_W-1:0] aw_addr_q;
  reg               w_hold_q;
  reg  [7:0]        w_data_q;
  reg               w_strb_q;
  wire [11:0]       src_ua;

  // Byte address of a register index
  function [ADDR_W-1:0] byte_addr;
    input [7:0] idx;
    begin
      byte_addr = {idx[ADDR_W-3:0], 2'b00};
    end
  endfunction

  function hits;
    input [ADDR_W-1:0] a;
    input [7:0]        idx;
    begin
      hits = ({a[ADDR_W-1:2], 2'b00} == byte_addr(idx));
    end
  endfunction

  // ********************
  // Write channel
  // ********************
  // Ready only when an edge can take the item
  assign s_axi_awready = ce && !aw_hold_q && !s_axi_bvalid;
  assign s_axi_wready  = ce && !w_hold_q && !s_axi_bvalid;

  wire aw_now   = s_axi_awvalid && s_axi_awready;
  wire w_now    = s_axi_wvalid && s_axi_wready;
  wire have_aw  = aw_hold_q || aw_now;
  wire have_w   = w_hold_q || w_now;
  wire [ADDR_W-1:0] wr_addr = aw_hold_q ? aw_addr_q : s_axi_awaddr;
  wire [7:0]        wr_data = w_hold_q ? w_data_q : s_axi_wdata[7:0];
  wire              wr_en   = w_hold_q ? w_strb_q : s_axi_wstrb[0];
  wire do_write = have_aw && have_w;
  wire wr_ref   = hits(wr_addr, `RXC_IDX_REFCTL);
  wire wr_mag   = hits(wr_addr, `RXC_IDX_MAG);

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q    <= 1'b0;
      aw_addr_q    <= {ADDR_W{1'b0}};
      w_hold_q     <= 1'b0;
      w_data_q     <= 8'h00;
      w_strb_q     <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RXC_RESP_OKAY;
      ref_q        <= `RXC_RST_REFCTL;
      mag_q        <= `RXC_RST_MAG;
    end else if (ce) begin
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (do_write) begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_ref || wr_mag) ? `RXC_RESP_OKAY : `RXC_RESP_SLVERR;
        if (wr_ref && wr_en) begin
          ref_q <= wr_data & `RXC_REFCTL_WMASK;
        end
        if (wr_mag && wr_en) begin
          mag_q <= wr_data & `RXC_MAG_WMASK;
        end
      end else begin
        if (aw_now) begin
          aw_hold_q <= 1'b1;
          aw_addr_q <= s_axi_awaddr;
        end
        if (w_now) begin
          w_hold_q <= 1'b1;
          w_data_q <= s_axi_wdata[7:0];
          w_strb_q <= s_axi_wstrb[0];
        end
      end
    end
  end

  // ********************
  // Read channel
  // ********************
  assign s_axi_arready = ce && !s_axi_rvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `RXC_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        if (hits(s_axi_araddr, `RXC_IDX_REFCTL)) begin
          s_axi_rdata <= {24'h000000, ref_q};
          s_axi_rresp <= `RXC_RESP_OKAY;
        end else if (hits(s_axi_araddr, `RXC_IDX_MAG)) begin
          s_axi_rdata <= {24'h000000, mag_q};
          s_axi_rresp <= `RXC_RESP_OKAY;
        end else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `RXC_RESP_SLVERR;
        end
      end
    end
  end

  // ********************
  // Field outputs
  // ********************
  always @(posedge aclk) begin
    if (!aresetn) begin
      ext_monitor_enable     <= 1'b0;
      pos_buffer_bypass      <= 1'b0;
      neg_buffer_bypass      <= 1'b1;
      basis_input_select     <= `RXC_SEL_PAIR0;
      internal_basis_power   <= `RXC_PWR_OFF;
      internal_basis_on      <= 1'b0;
      current_magnitude_code <= 4'h0;
      basis_warning          <= 1'b0;
    end else if (ce) begin
      ext_monitor_enable     <= ref_q[`RXC_BIT_MON];
      pos_buffer_bypass      <= ref_q[`RXC_BIT_PBYP];
      neg_buffer_bypass      <= ref_q[`RXC_BIT_NBYP];
      basis_input_select     <= ref_q[`RXC_SEL_HI:`RXC_SEL_LO];
      internal_basis_power   <= ref_q[`RXC_PWR_HI:`RXC_PWR_LO];
      internal_basis_on      <= (ref_q[`RXC_PWR_HI:`RXC_PWR_LO] == `RXC_PWR_SLEEPOFF) ||
                                (ref_q[`RXC_PWR_HI:`RXC_PWR_LO] == `RXC_PWR_ALWAYS);
      current_magnitude_code <= mag_q[`RXC_MAG_HI:`RXC_MAG_LO];
      basis_warning <= ((mag_q[`RXC_MAG_HI:`RXC_MAG_LO] != 4'h0) &&
                        (ref_q[`RXC_PWR_HI:`RXC_PWR_LO] == `RXC_PWR_OFF)) ||
                       ((ref_q[`RXC_SEL_HI:`RXC_SEL_LO] == `RXC_SEL_INTERNAL) &&
                        !(ref_q[`RXC_BIT_PBYP] && ref_q[`RXC_BIT_NBYP]));
    end
  end

  rxc_field_decode u_field (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .ce           (ce),
    .sel          (ref_q[`RXC_SEL_HI:`RXC_SEL_LO]),
    .pwr          (ref_q[`RXC_PWR_HI:`RXC_PWR_LO]),
    .sel_onehot_q (basis_select_onehot),
    .pwr_onehot_q (basis_power_onehot)
  );

  rxc_mag_decode u_mag (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .ce           (ce),
    .code         (mag_q[`RXC_MAG_HI:`RXC_MAG_LO]),
    .microamps_q  (src_ua),
    .code_valid_q (current_code_valid)
  );

  assign current_source_one = src_ua;
  assign current_source_two = src_ua;

endmodule // rxc_ref_exc_regs

// [rxc_ref_exc_monitor.sv]
// Checker for the reference and excitation register block
`timescale 1ns/100ps
module rxc_ref_exc_monitor (
  // Clock and bus
  input wire        aclk,
  input wire        aresetn,
  input wire        ce,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_rvalid,
  // Fields
  input wire        pos_buffer_bypass,
  input wire        neg_buffer_bypass,
  input wire [1:0]  basis_input_select,
  input wire [1:0]  internal_basis_power,
  input wire [3:0]  basis_select_onehot,
  input wire        internal_basis_on,
  input wire [3:0]  current_magnitude_code,
  input wire [11:0] current_source_one,
  input wire [11:0] current_source_two
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ********************
  // Properties
  // ********************
  property p_rst_ref;
    disable iff (1'b0) !aresetn ##1 !aresetn |-> neg_buffer_bypass && !pos_buffer_bypass && basis_input_select == 2'h0;
  endproperty
  a_rst_ref: assert property (p_rst_ref) else $error("reference reset value wrong");
  property p_rst_mag;
    disable iff (1'b0) !aresetn ##1 !aresetn |-> current_magnitude_code == 4'h0 && current_source_one == 12'h0;
  endproperty
  a_rst_mag: assert property (p_rst_mag) else $error("magnitude reset value wrong");
  property p_same;
    current_source_one == current_source_two;
  endproperty
  a_same: assert property (p_same) else $error("current sources differ");
  property p_off;
    current_magnitude_code == 4'h0 [*2] |-> current_source_one == 12'h000;
  endproperty
  a_off: assert property (p_off) else $error("code zero not off");
  property p_top;
    current_magnitude_code == 4'h9 [*2] |-> current_source_one == 12'h7d0;
  endproperty
  a_top: assert property (p_top) else $error("top code current wrong");
  property p_onehot;
    $stable(basis_input_select) [*2] |-> basis_select_onehot == (4'h1 << basis_input_select);
  endproperty
  a_onehot: assert property (p_onehot) else $error("source decode wrong");
  property p_pwr;
    $stable(internal_basis_power) [*2] |-> internal_basis_on == (internal_basis_power inside {2'h1, 2'h2});
  endproperty
  a_pwr: assert property (p_pwr) else $error("power decode wrong");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_rd;
    ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd: assert property (p_rd) else $error("read answer late");
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
  c_err: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  c_top: cover property (current_magnitude_code == 4'h9 [*2]);
endmodule // rxc_ref_exc_monitor

bind rxc_ref_exc_regs rxc_ref_exc_monitor u_mon (.aclk, .aresetn, .ce, .s_axi_arvalid, .s_axi_arready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_rvalid, .pos_buffer_bypass, .neg_buffer_bypass,
  .basis_input_select, .internal_basis_power, .basis_select_onehot, .internal_basis_on,
  .current_magnitude_code, .current_source_one, .current_source_two);

// [rxc_ref_exc_regs_tb.sv]
// Self-checking bench for the reference and excitation registers
`timescale 1ns/100ps
module rxc_ref_exc_regs_tb;
  logic        aclk = 0, aresetn = 0, ce = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic [7:0]  awa = 0, ara = 0;
  logic [31:0] wd = 0;
  logic [2:0]  prot = 0;
  logic [3:0]  strb = 4'h1;
  wire         awrdy, wrdy, bv, arrdy, rv, ext, pos, neg, ibon, cval, warn;
  wire  [1:0]  bresp, rresp, sel, pwr;
  wire  [31:0] rdata;
  wire  [3:0]  mag, soh, poh;
  wire  [11:0] cs1, cs2;
  int          err_count = 0, compares = 0;
  logic [11:0] ua [16] = '{12'h000, 12'h00a, 12'h032, 12'h064, 12'h0fa, 12'h1f4, 12'h2ee, 12'h3e8, 12'h5dc, 12'h7d0,
                           12'h000, 12'h000, 12'h000, 12'h000, 12'h000, 12'h000};
  rxc_ref_exc_regs dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awvalid(awv), .s_axi_awready(awrdy),
    .s_axi_awaddr(awa), .s_axi_awprot(prot), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_wdata(wd),
    .s_axi_wstrb(strb), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_bresp(bresp), .s_axi_arvalid(arv),
    .s_axi_arready(arrdy), .s_axi_araddr(ara), .s_axi_arprot(prot), .s_axi_rvalid(rv), .s_axi_rready(rry),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .ext_monitor_enable(ext), .pos_buffer_bypass(pos),
    .neg_buffer_bypass(neg), .basis_input_select(sel), .internal_basis_power(pwr), .basis_select_onehot(soh),
    .basis_power_onehot(poh), .internal_basis_on(ibon), .current_magnitude_code(mag), .current_source_one(cs1),
    .current_source_two(cs2), .current_code_valid(cval), .basis_warning(warn));
  always #5 aclk = ~aclk;
  // ********************
  // Shared tasks
  // ********************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Response held back to show bvalid standing
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awv && awrdy) awv <= 1'b0;
      if (wv && wrdy) wv <= 1'b0;
    end while (!bv && n < 40);
    if (!bv) begin
      err_count++;
      close_out();
    end
    bry <= 1'b1;
    @(posedge aclk);
    chk(bresp, er);
    bry <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arv && arrdy) arv <= 1'b0;
    end while (!rv && n < 40);
    if (!rv) begin
      err_count++;
      close_out();
    end
    chk(rdata, ed);
    chk(rresp, er);
    rry <= 1'b0;
  endtask
  // ********************
  // Scenarios
  // ********************
  task automatic t_reset;
    rd(8'h14, 32'h10, 2'h0);
    rd(8'h18, 32'h0, 2'h0);
    chk({ext, pos, neg, sel, pwr, mag}, 11'h100);
  endtask
  task automatic t_ref;
    logic [7:0] v;
    for (int i = 0; i < 128; i++) begin
      v = i[7:0];
      if (v[3:2] == 2'h2) v[5:4] = 2'h3;
      wr(8'h14, {24'h0, v}, 2'h0);
      chk({ext, pos, neg, sel, pwr}, v[6:0]);
      chk(soh, 4'h1 << v[3:2]);
      chk({ibon, poh}, {v[1:0] == 2'h1 || v[1:0] == 2'h2, 4'h1 << v[1:0]});
      chk(warn, 1'b0);
      rd(8'h14, {24'h0, v}, 2'h0);
    end
  endtask
  task automatic t_mag;
    wr(8'h14, 32'h1, 2'h0);
    for (int c = 0; c < 16; c++) begin
      wr(8'h18, c, 2'h0);
      chk(mag, c);
      chk({cval, cs1}, {c < 10, ua[c]});
      chk(cs2, ua[c]);
      chk(warn, 1'b0);
      rd(8'h18, c, 2'h0);
    end
  endtask
  // Write offered while frozen must wait for the enable
  task automatic t_ce;
    ce <= 1'b0;
    fork
      wr(8'h18, 32'h5, 2'h0);
      begin
        repeat (5) @(posedge aclk);
        chk({bv, mag}, 5'h0f);
        ce <= 1'b1;
      end
    join
    chk(mag, 4'h5);
  endtask
  task automatic t_bad;
    wr(8'h1c, 32'h55, 2'h2);
    rd(8'h1c, 32'h0, 2'h2);
    strb <= 4'h0;
    wr(8'h18, 32'h3, 2'h0);
    strb <= 4'h1;
    rd(8'h18, 32'h5, 2'h0);
    rd(8'h14, 32'h1, 2'h0);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
  endtask
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_ref();
    t_mag();
    t_ce();
    t_bad();
    close_out();
  end
endmodule // rxc_ref_exc_regs_tb
